// [bbec_pkg.sv]
// Constants, register map and field layout for the backplane error capture
package bbec_pkg;
    // Register byte addresses in local I/O space
    localparam logic [31:0] ADDR_SYS_CONFIG = 32'h2008_0000;
    localparam logic [31:0] ADDR_DMA_SYS_ERR = 32'h2008_0004;
    localparam logic [31:0] ADDR_BP_ERR_PAGE = 32'h2008_0008;
    localparam logic [31:0] ADDR_LM_ERR_PAGE = 32'h2008_000c;
    // dma_system_error_flags bit positions
    localparam int DMA_SYSTEM_ERROR_FLAGS_MTO = 7;
    localparam int DMA_SYSTEM_ERROR_FLAGS_PAR = 5;
    localparam int DMA_SYSTEM_ERROR_FLAGS_MME = 4;
    localparam int DMA_SYSTEM_ERROR_FLAGS_LOST = 3;
    localparam int DMA_SYSTEM_ERROR_FLAGS_NGTO = 2;
    localparam logic [31:0] DMA_SYSTEM_ERROR_FLAGS_RESET = 32'h0000_0000;
    // system_configuration power-OK bit
    localparam int SCR_POK = 15;
    // Page field layouts
    localparam int BP_ADDR_W = 22;
    localparam int BP_PAGE_LSB = 9;
    localparam int BP_PAGE_W = 13;
    localparam int LM_ADDR_W = 29;
    localparam int LM_PAGE_W = 20;
    // Reference kinds presented by the processor side
    localparam logic [2:0] KIND_DEMAND_RD = 3'h0;
    localparam logic [2:0] KIND_PREFETCH = 3'h1;
    localparam logic [2:0] KIND_IACK = 3'h2;
    localparam logic [2:0] KIND_MASKED_WR = 3'h3;
    localparam logic [2:0] KIND_WRITE = 3'h4;
    // Interrupt levels and vectors
    localparam logic [4:0] IPL_HARD_ERR = 5'h1d;
    localparam logic [7:0] VEC_WRITE_NXM = 8'h60;
    localparam logic [7:0] VEC_POWER_FAIL = 8'h0c;
    // Timing
    localparam int CLK_MHZ = 125;
    localparam int NXM_TIMEOUT_NS = 10000;
    localparam int NO_ACK_TIMEOUT_NS = 10000;
    localparam int CHAIN_CLEAR_NS = 500;
    localparam int NO_GRANT_TIMEOUT_MS = 10;
    localparam int NXM_CYC = (NXM_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int NO_ACK_CYC = (NO_ACK_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
    localparam int CHAIN_CLEAR_CYC = (CHAIN_CLEAR_NS * CLK_MHZ + 999) / 1000;
    localparam int NO_GRANT_CYC = NO_GRANT_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int TMR_W = 21;
    // State types
    typedef enum logic [1:0] {REF_IDLE, REF_GRANT, REF_REPLY} bbec_ref_st_t;
    typedef enum logic [1:0] {DMA_IDLE, DMA_GRANT, DMA_BUSY, DMA_CLEAR}
        bbec_dma_st_t;
endpackage

// [bbec_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bbec_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Data
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage feeds only the second stage
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            meta_ff <= '0;
            q_ff <= '0;
        end
        else
        begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end

    assign q_o = q_ff;
endmodule

// [bbec_timer.sv]
// Loadable down-counting timeout timer with one-cycle expiry pulse
`timescale 1ns/1ps
module bbec_timer #(
    parameter int W = 21
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    // Control
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [W-1:0] load_i,
    output logic expire_o
);
    logic [W-1:0] cnt_ff;
    logic run_ff;
    logic expire_ff;
    logic last;

    assign last = run_ff && (cnt_ff == {{(W-1){1'b0}}, 1'b1});

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            expire_ff <= 1'b0;
        end
        else
        begin
            expire_ff <= last && !stop_i && !start_i;
            if (start_i)
            begin
                cnt_ff <= load_i;
                run_ff <= 1'b1;
            end
            else if (stop_i || last)
                run_ff <= 1'b0;
            else if (run_ff)
                cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign expire_o = expire_ff;
endmodule

// [bbec_top.sv]
// Backplane bus error detection, capture and error page registers
`timescale 1ns/1ps
// What this block does
// - Capture backplane page bits into error page
// - Lost flag on error while page held
// - Write to error page raises hard error
// - Local page valid while memory flag set
// - Latch local page once until cleared
// - Mapped bits 28:9 into local page
// - No parity generated or checked locally
// - Non-longword backplane reference makes machine check
// - Demand read timeout: flag, capture, check
// - Prefetch or vector read timeout: abort only
// - Write timeout: flag, capture, interrupt
// - DMA ack timeout: drop grant, wait
// - Demand read no grant in 10 ms: flag, check
// - Sample data lines 17:16 as parity
// - Demand read parity: flag, capture, check
// - Prefetch parity: abort, flag, capture
// - Power-OK negation raises power-fail trap
// - Power-OK ANDed with DC-OK level shown in configuration bit
// - Flags set on event, write one clears
// - Flags cleared by reset, DC-OK, I/O reset
module bbec_top
    import bbec_pkg::*;
#(
    parameter int NO_GRANT_CYCLES = NO_GRANT_CYC
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Processor register access
    input wire logic reg_sel_i,
    input wire logic reg_wr_i,
    input wire logic reg_lw_i,
    input wire logic [31:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic reg_ack_o,
    output logic [31:0] reg_rdata_o,
    // Processor backplane reference
    input wire logic ref_valid_i,
    input wire logic [2:0] ref_kind_i,
    input wire logic ref_longword_i,
    input wire logic [21:0] ref_addr_i,
    output logic ref_done_o,
    output logic ref_abort_o,
    output logic machine_check_o,
    // Interrupts and traps
    output logic hard_error_irq_o,
    output logic write_err_irq_o,
    output logic power_fail_trap_o,
    // Backplane pins
    input wire logic bus_grant_i,
    input wire logic bus_reply_i,
    input wire logic [1:0] bus_parity_i,
    input wire logic bpok_i,
    input wire logic dcok_i,
    output logic bus_req_o,
    // DMA arbitration pins
    input wire logic dma_req_i,
    input wire logic dma_ack_i,
    output logic dma_grant_o,
    // Local memory errors and I/O reset
    input wire logic mem_err_i,
    input wire logic [28:0] mem_err_addr_i,
    input wire logic io_reset_i
);
    generate
        if (NO_GRANT_CYCLES < 2 || NO_GRANT_CYCLES >= (1 << TMR_W))
        begin : g_bad_param
            $error("NO_GRANT_CYCLES out of timer range");
        end
    endgenerate

    logic [1:0] rst_sync_ff;
    logic rst_n;
    logic grant_s, reply_s, bpok_s, dcok_s, dreq_s, dack_s;
    logic [1:0] par_s;
    logic bpok_d_ff, dcok_d_ff;
    bbec_ref_st_t ref_st_ff, nxt_ref_st;
    bbec_dma_st_t dma_st_ff, nxt_dma_st;
    logic [2:0] kind_ff;
    logic [21:0] addr_ff;
    logic mto_ff, par_ff, mme_ff, lost_ff, ngto_ff, pok_ff;
    logic [BP_PAGE_W-1:0] bp_page_ff;
    logic [LM_PAGE_W-1:0] lm_page_ff;
    logic ack_ff, done_ff, abort_ff, mchk_ff, hard_ff, wirq_ff, trap_ff;
    logic breq_ff, dgnt_ff;
    logic [31:0] rdata_ff;

    // Reset release through two flops
    always_ff @(posedge ref_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    // Pin synchronisers
    bbec_sync #(.W(8)) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .d_i({bus_grant_i, bus_reply_i, bus_parity_i, bpok_i, dcok_i,
              dma_req_i, dma_ack_i}),
        .q_o({grant_s, reply_s, par_s, bpok_s, dcok_s, dreq_s, dack_s})
    );

    // Register decode
    wire wr_acc = reg_sel_i && reg_wr_i;
    wire hit_scr = reg_addr_i == ADDR_SYS_CONFIG;
    wire hit_dma_system_error_flags = reg_addr_i == ADDR_DMA_SYS_ERR;
    wire hit_bp = reg_addr_i == ADDR_BP_ERR_PAGE;
    wire hit_lm = reg_addr_i == ADDR_LM_ERR_PAGE;
    wire page_wr = wr_acc && (hit_bp || hit_lm);
    wire dma_system_error_flags_wr = wr_acc && hit_dma_system_error_flags;
    wire flag_rst = (dcok_d_ff && !dcok_s) || io_reset_i;
    wire [31:0] dma_system_error_flags_val = {24'h0, mto_ff, 1'b0, par_ff, mme_ff, lost_ff,
                            ngto_ff, 2'h0};
    wire [31:0] scr_val = {16'h0, pok_ff, 15'h0};
    wire [31:0] bp_val = {19'h0, bp_page_ff};
    wire [31:0] lm_val = {12'h0, lm_page_ff};
    wire page_rd_ok = reg_lw_i;
    wire [31:0] rd_mux = hit_scr ? scr_val :
                         hit_dma_system_error_flags ? dma_system_error_flags_val :
                         (hit_bp && page_rd_ok) ? bp_val :
                         (hit_lm && page_rd_ok) ? lm_val : 32'h0;

    // Write-one-to-clear per flag
    function automatic logic w1c(input logic wr, input logic [31:0] d,
                                 input int bit_pos);
        w1c = wr && d[bit_pos];
    endfunction

    // Shared reference timer: grant wait then reply wait
    logic ref_tmr_start, ref_tmr_stop, ref_tmr_exp;
    logic [TMR_W-1:0] ref_tmr_load;
    bbec_timer #(.W(TMR_W)) u_ref_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .start_i(ref_tmr_start),
        .stop_i(ref_tmr_stop),
        .load_i(ref_tmr_load),
        .expire_o(ref_tmr_exp)
    );

    logic dma_tmr_start, dma_tmr_exp;
    logic [TMR_W-1:0] dma_tmr_load;
    bbec_timer #(.W(TMR_W)) u_dma_tmr (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n),
        .start_i(dma_tmr_start),
        .stop_i(1'b0),
        .load_i(dma_tmr_load),
        .expire_o(dma_tmr_exp)
    );

    // Reference checking
    wire is_drd = kind_ff == KIND_DEMAND_RD;
    wire is_pf = kind_ff == KIND_PREFETCH;
    wire is_wr = kind_ff == KIND_MASKED_WR || kind_ff == KIND_WRITE;
    wire ref_go = ref_st_ff == REF_IDLE && ref_valid_i && dma_st_ff == DMA_IDLE;
    wire bad_type = ref_go && !ref_longword_i;
    wire ref_start = ref_go && ref_longword_i;
    wire in_reply = ref_st_ff == REF_REPLY;
    // Parity is only observed from the target; none computed here
    wire par_hit = in_reply && reply_s && (par_s != 2'h0)
                   && (is_drd || is_pf);
    wire nxm_exp = in_reply && !reply_s && ref_tmr_exp;
    wire ngnt_exp = ref_st_ff == REF_GRANT && !grant_s && ref_tmr_exp;
    wire par_evt = par_hit;
    wire mto_evt = nxm_exp && (is_drd || is_wr);
    wire ngto_evt = ngnt_exp && is_drd;
    wire bp_held = mto_ff || par_ff;
    wire bp_cap = (par_evt || mto_evt) && !bp_held;
    wire lost_evt = ((par_evt || mto_evt) && bp_held)
                    || (mem_err_i && mme_ff);
    wire mchk_evt = bad_type || (par_evt && is_drd) || (mto_evt && is_drd)
                    || ngto_evt;
    wire abort_evt = bad_type || (par_evt && is_pf)
                     || (nxm_exp && !mto_evt) || (ngnt_exp && !is_drd);
    wire ok_evt = in_reply && reply_s && !par_hit;

    always_comb
    begin
        nxt_ref_st = ref_st_ff;
        ref_tmr_start = 1'b0;
        ref_tmr_stop = 1'b0;
        ref_tmr_load = TMR_W'(NO_GRANT_CYCLES);
        case (ref_st_ff)
            REF_IDLE:
            begin
                if (ref_start)
                begin
                    nxt_ref_st = REF_GRANT;
                    ref_tmr_start = 1'b1;
                end
            end
            REF_GRANT:
            begin
                if (grant_s)
                begin
                    nxt_ref_st = REF_REPLY;
                    ref_tmr_start = 1'b1;
                    ref_tmr_load = TMR_W'(NXM_CYC);
                end
                else if (ref_tmr_exp)
                    nxt_ref_st = REF_IDLE;
            end
            REF_REPLY:
            begin
                if (reply_s || ref_tmr_exp)
                begin
                    nxt_ref_st = REF_IDLE;
                    ref_tmr_stop = 1'b1;
                end
            end
            default: nxt_ref_st = REF_IDLE;
        endcase
    end

    // DMA grant arbitration
    always_comb
    begin
        nxt_dma_st = dma_st_ff;
        dma_tmr_start = 1'b0;
        dma_tmr_load = TMR_W'(NO_ACK_CYC);
        case (dma_st_ff)
            DMA_IDLE:
            begin
                if (dreq_s && ref_st_ff == REF_IDLE && !ref_valid_i)
                begin
                    nxt_dma_st = DMA_GRANT;
                    dma_tmr_start = 1'b1;
                end
            end
            DMA_GRANT:
            begin
                if (dack_s)
                    nxt_dma_st = DMA_BUSY;
                else if (dma_tmr_exp)
                begin
                    nxt_dma_st = DMA_CLEAR;
                    dma_tmr_start = 1'b1;
                    dma_tmr_load = TMR_W'(CHAIN_CLEAR_CYC);
                end
            end
            DMA_BUSY:
                if (!dack_s)
                    nxt_dma_st = DMA_IDLE;
            DMA_CLEAR:
                if (dma_tmr_exp)
                    nxt_dma_st = DMA_IDLE;
            default: nxt_dma_st = DMA_IDLE;
        endcase
    end

    // Flag next values: set wins over a same-cycle clear
    wire clr_mto = w1c(dma_system_error_flags_wr, reg_wdata_i, DMA_SYSTEM_ERROR_FLAGS_MTO) || flag_rst;
    wire clr_par = w1c(dma_system_error_flags_wr, reg_wdata_i, DMA_SYSTEM_ERROR_FLAGS_PAR) || flag_rst;
    wire clr_mme = w1c(dma_system_error_flags_wr, reg_wdata_i, DMA_SYSTEM_ERROR_FLAGS_MME) || flag_rst;
    wire clr_lost = w1c(dma_system_error_flags_wr, reg_wdata_i, DMA_SYSTEM_ERROR_FLAGS_LOST) || flag_rst;
    wire clr_ngto = w1c(dma_system_error_flags_wr, reg_wdata_i, DMA_SYSTEM_ERROR_FLAGS_NGTO) || flag_rst;
    wire nxt_mto = mto_evt || (mto_ff && !clr_mto);
    wire nxt_par = par_evt || (par_ff && !clr_par);
    wire nxt_mme = mem_err_i || (mme_ff && !clr_mme);
    wire nxt_lost = lost_evt || (lost_ff && !clr_lost);
    wire nxt_ngto = ngto_evt || (ngto_ff && !clr_ngto);

    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_st_ff <= REF_IDLE;
            dma_st_ff <= DMA_IDLE;
            kind_ff <= KIND_DEMAND_RD;
            addr_ff <= 22'h0;
            {mto_ff, par_ff, mme_ff, lost_ff, ngto_ff} <= 5'h0;
        end
        else
        begin
            ref_st_ff <= nxt_ref_st;
            dma_st_ff <= nxt_dma_st;
            if (ref_start)
            begin
                kind_ff <= ref_kind_i;
                addr_ff <= ref_addr_i;
            end
            {mto_ff, par_ff, mme_ff, lost_ff, ngto_ff} <=
                {nxt_mto, nxt_par, nxt_mme, nxt_lost, nxt_ngto};
        end
    end

    // Page capture registers, no reset value needed by software
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bp_page_ff <= '0;
            lm_page_ff <= '0;
        end
        else
        begin
            if (bp_cap)
                bp_page_ff <= addr_ff[BP_ADDR_W-1:BP_PAGE_LSB];
            if (mem_err_i && !mme_ff)
                lm_page_ff <= mem_err_addr_i[LM_ADDR_W-1:9];
        end
    end

    // Outputs and pulses
    always_ff @(posedge ref_clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {ack_ff, done_ff, abort_ff, mchk_ff} <= 4'h0;
            {hard_ff, wirq_ff, trap_ff, breq_ff, dgnt_ff} <= 5'h0;
            {bpok_d_ff, dcok_d_ff, pok_ff} <= 3'h0;
            rdata_ff <= 32'h0;
        end
        else
        begin
            ack_ff <= reg_sel_i;
            rdata_ff <= (reg_sel_i && !reg_wr_i) ? rd_mux : 32'h0;
            done_ff <= ok_evt || mchk_evt || abort_evt || (mto_evt && is_wr);
            abort_ff <= abort_evt;
            mchk_ff <= mchk_evt;
            hard_ff <= page_wr;
            wirq_ff <= mto_evt && is_wr;
            trap_ff <= bpok_d_ff && !bpok_s;
            breq_ff <= nxt_ref_st == REF_GRANT;
            dgnt_ff <= nxt_dma_st == DMA_GRANT;
            bpok_d_ff <= bpok_s;
            dcok_d_ff <= dcok_s;
            pok_ff <= bpok_s && dcok_s;
        end
    end

    assign reg_ack_o = ack_ff;
    assign reg_rdata_o = rdata_ff;
    assign ref_done_o = done_ff;
    assign ref_abort_o = abort_ff;
    assign machine_check_o = mchk_ff;
    assign hard_error_irq_o = hard_ff;
    assign write_err_irq_o = wirq_ff;
    assign power_fail_trap_o = trap_ff;
    assign bus_req_o = breq_ff;
    assign dma_grant_o = dgnt_ff;

    AST_BP_PAGE_CAPTURE: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        bp_cap |=> bp_page_ff == $past(addr_ff[21:9]))
        else $error("backplane page not captured");
    AST_LOST_FLAG: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        (par_evt || mto_evt) && bp_held |=> lost_ff && $stable(bp_page_ff))
        else $error("lost flag not set or page overwritten");
    AST_PAGE_WRITE_IRQ: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        reg_sel_i && reg_wr_i && (hit_bp || hit_lm) |=> hard_error_irq_o)
        else $error("page register write gave no hard error");
    AST_LM_PAGE_HOLD: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        mme_ff && $past(mme_ff) |-> $stable(lm_page_ff))
        else $error("local page changed while held");
    AST_LM_PAGE_UPPER: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        reg_sel_i && !reg_wr_i && reg_lw_i && hit_lm
        |=> reg_rdata_o[31:20] == 12'h0 && reg_ack_o)
        else $error("local page upper bits not zero");
    AST_BAD_TYPE_MCHK: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        bad_type |=> machine_check_o && ref_abort_o && !bus_req_o)
        else $error("bad reference type not checked");
    AST_NXM_DEMAND: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        nxm_exp && is_drd |=> mto_ff && machine_check_o)
        else $error("demand read timeout not reported");
    AST_NXM_PREFETCH: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        nxm_exp && !is_drd && !is_wr
        |=> ref_abort_o && !machine_check_o && $stable(bp_page_ff))
        else $error("prefetch timeout did more than abort");
    AST_DMA_CLEAR: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        dma_st_ff == DMA_GRANT && nxt_dma_st == DMA_CLEAR
        |=> !dma_grant_o [*8])
        else $error("grant not withdrawn after ack timeout");
    AST_POWER_TRAP: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        $fell(bpok_s) |=> power_fail_trap_o ##1 !pok_ff)
        else $error("power-fail trap missing");
    AST_W1C: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n)
        dma_system_error_flags_wr && !reg_wdata_i[DMA_SYSTEM_ERROR_FLAGS_PAR] && !flag_rst && par_ff
        |=> par_ff)
        else $error("writing zero cleared a flag");
endmodule

// [bbec_bus_model.sv]
// Far side of the backplane: bus grant, slave reply and parity report
`timescale 1ns/1ps
module bbec_bus_model (
    // Clock and design outputs it watches
    input wire logic ref_clk_i,
    input wire logic bus_req_i,
    input wire logic ref_done_i,
    // Behaviour chosen by the bench
    input wire logic give_grant_i,
    input wire logic give_reply_i,
    input wire logic [1:0] parity_i,
    // Backplane pins into the design
    output logic bus_grant_o,
    output logic bus_reply_o,
    output logic [1:0] bus_parity_o
);
    initial
    begin
        bus_grant_o = 1'b0;
        bus_reply_o = 1'b0;
        bus_parity_o = 2'h3;
        forever
        begin
            @(posedge ref_clk_i);
            if (bus_req_i && give_grant_i)
            begin
                repeat (3) @(posedge ref_clk_i);
                bus_grant_o <= 1'b1;
                repeat (5) @(posedge ref_clk_i);
                bus_parity_o <= give_reply_i ? parity_i : 2'h3;
                bus_reply_o <= give_reply_i;
                // Held until the cycle ends, so a slow design still sees it
                for (int i = 0; i < 3000 && !ref_done_i; i++)
                    @(posedge ref_clk_i);
                bus_grant_o <= 1'b0;
                bus_reply_o <= 1'b0;
                // Released data lines do not keep their last value
                bus_parity_o <= ~bus_parity_o;
            end
        end
    end
endmodule

// [tb.sv]
// Self-checking bench for the backplane error capture block
`timescale 1ns/1ps
module tb;
    import bbec_pkg::*;
    logic ref_clk_i, nrst_i, reg_sel_i, reg_wr_i, reg_lw_i, reg_ack_o;
    logic [31:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic ref_valid_i, ref_longword_i, ref_done_o, ref_abort_o;
    logic [2:0] ref_kind_i;
    logic [21:0] ref_addr_i, a0, a1;
    logic machine_check_o, hard_error_irq_o, write_err_irq_o;
    logic power_fail_trap_o, bus_grant_i, bus_reply_i, bpok_i, dcok_i;
    logic [1:0] bus_parity_i, par;
    logic bus_req_o, dma_req_i, dma_ack_i, dma_grant_o, mem_err_i;
    logic io_reset_i, g_en, r_en;
    logic [28:0] mem_err_addr_i, m1;
    logic [32:0] rq[$];
    logic [3:0] fq[$], e;
    logic [3:0] te[5] = '{4'h2, 4'hc, 4'hc, 4'h1, 4'h1};
    logic [7:0] td[5] = '{8'h80, 8'h0, 8'h0, 8'h80, 8'h80};
    int n_errors = 0, checks = 0, seed, n;
    wire logic [2:0] mon = {dma_grant_o, power_fail_trap_o, ref_done_o};

    initial
    begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    bbec_top #(.NO_GRANT_CYCLES(50)) u_dut (
        .ref_clk_i, .nrst_i, .reg_sel_i, .reg_wr_i, .reg_lw_i, .reg_addr_i,
        .reg_wdata_i, .reg_ack_o, .reg_rdata_o, .ref_valid_i, .ref_kind_i,
        .ref_longword_i, .ref_addr_i, .ref_done_o, .ref_abort_o,
        .machine_check_o, .hard_error_irq_o, .write_err_irq_o,
        .power_fail_trap_o, .bus_grant_i, .bus_reply_i, .bus_parity_i,
        .bpok_i, .dcok_i, .bus_req_o, .dma_req_i, .dma_ack_i, .dma_grant_o,
        .mem_err_i, .mem_err_addr_i, .io_reset_i
    );

    bbec_bus_model u_bus (
        .ref_clk_i, .bus_req_i(bus_req_o), .ref_done_i(ref_done_o),
        .give_grant_i(g_en), .give_reply_i(r_en), .parity_i(par),
        .bus_grant_o(bus_grant_i), .bus_reply_o(bus_reply_i),
        .bus_parity_o(bus_parity_i)
    );

    task automatic report_and_stop();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(string nm, logic [32:0] seen, logic [32:0] x);
        checks++;
        if (seen !== x)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, x, seen);
        end
    endtask

    task automatic wt(int b, logic v, int lim);
        for (n = 0; mon[b] !== v; n++)
        begin
            if (n == lim)
            begin
                n_errors++;
                report_and_stop();
            end
            @(negedge ref_clk_i);
        end
    endtask

    task automatic rg(logic wr, logic lw, logic [31:0] a, logic [31:0] d,
                      logic [32:0] x);
        @(negedge ref_clk_i);
        {reg_sel_i, reg_wr_i, reg_lw_i, reg_addr_i} = {1'b1, wr, lw, a};
        reg_wdata_i = d;
        rq.push_back(x);
        @(negedge ref_clk_i);
        reg_sel_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
    endtask

    task automatic rd(logic [31:0] a, logic [32:0] x);
        rg(1'b0, 1'b1, a, 32'h0, x);
    endtask

    task automatic rf(logic [2:0] k, logic lw, logic g, logic r,
                      logic [1:0] p, logic [3:0] x);
        @(negedge ref_clk_i);
        {g_en, r_en, par, ref_kind_i, ref_longword_i} = {g, r, p, k, lw};
        ref_addr_i = 22'($random(seed));
        fq.push_back(x);
        ref_valid_i = 1'b1;
        wt(0, 1'b1, 3000);
        ref_valid_i = 1'b0;
        a1 = ref_addr_i;
        // Let the released grant and reply clear the pin synchronisers
        repeat (4) @(negedge ref_clk_i);
    endtask

    task automatic pulse_io_reset();
        @(negedge ref_clk_i);
        io_reset_i = 1'b1;
        @(negedge ref_clk_i);
        io_reset_i = 1'b0;
    endtask

    // Results come back in request order, so one queue per interface
    always @(posedge ref_clk_i)
    begin
        if (reg_ack_o === 1'b1)
            check("reg", {hard_error_irq_o, reg_rdata_o},
                  rq.size() ? rq.pop_front() : 33'hx);
        if (ref_done_o === 1'b1)
        begin
            e = fq.size() ? fq.pop_front() : 4'hx;
            check("ref", {30'h0, ref_abort_o, machine_check_o,
                  write_err_irq_o}, {30'h0, e[2:0]});
        end
    end

    initial
    begin
        seed = 32'h54d9;
        {reg_sel_i, reg_wr_i, reg_lw_i, reg_addr_i, reg_wdata_i} = '0;
        {ref_valid_i, ref_kind_i, ref_longword_i, ref_addr_i} = '0;
        {dma_req_i, mem_err_i, mem_err_addr_i, io_reset_i} = '0;
        // DMA acknowledge stays low until the timeout path has been seen
        dma_ack_i = 1'b0;
        {bpok_i, dcok_i, nrst_i, g_en, r_en, par} = 7'h6c;
        repeat (8) @(negedge ref_clk_i);
        nrst_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        rd(ADDR_DMA_SYS_ERR, 33'h0);
        rd(ADDR_SYS_CONFIG, 33'h8000);
        rd(32'h2008_0020, 33'h0);
        rg(1'b1, 1'b1, ADDR_BP_ERR_PAGE, 32'hffff_ffff, 33'h1_0000_0000);
        rg(1'b1, 1'b1, ADDR_LM_ERR_PAGE, 32'hffff_ffff, 33'h1_0000_0000);
        rf(KIND_DEMAND_RD, 1'b0, 1'b1, 1'b1, 2'h0, 4'he);
        rf(KIND_DEMAND_RD, 1'b1, 1'b1, 1'b1, 2'h0, 4'h8);
        rf(KIND_DEMAND_RD, 1'b1, 1'b1, 1'b1, 2'h1, 4'h2);
        rd(ADDR_DMA_SYS_ERR, 33'h20);
        rd(ADDR_BP_ERR_PAGE, {20'h0, a1[21:9]});
        rg(1'b0, 1'b0, ADDR_BP_ERR_PAGE, 32'h0, 33'h0);
        a0 = a1;
        rf(KIND_PREFETCH, 1'b1, 1'b1, 1'b1, 2'h2, 4'hc);
        rd(ADDR_DMA_SYS_ERR, 33'h28);
        rd(ADDR_BP_ERR_PAGE, {20'h0, a0[21:9]});
        rg(1'b1, 1'b1, ADDR_DMA_SYS_ERR, 32'h0, 33'h0);
        rd(ADDR_DMA_SYS_ERR, 33'h28);
        rg(1'b1, 1'b1, ADDR_DMA_SYS_ERR, 32'hff, 33'h0);
        rd(ADDR_DMA_SYS_ERR, 33'h0);
        for (int k = 0; k < 5; k++)
        begin
            rf(k[2:0], 1'b1, 1'b1, 1'b0, 2'h0, te[k]);
            rd(ADDR_DMA_SYS_ERR, {25'h0, td[k]});
            if (td[k] != 8'h0)
                rd(ADDR_BP_ERR_PAGE, {20'h0, a1[21:9]});
            rg(1'b1, 1'b1, ADDR_DMA_SYS_ERR, 32'hff, 33'h0);
        end
        rf(KIND_DEMAND_RD, 1'b1, 1'b0, 1'b1, 2'h0, 4'h2);
        rd(ADDR_DMA_SYS_ERR, 33'h4);
        pulse_io_reset();
        rd(ADDR_DMA_SYS_ERR, 33'h0);
        m1 = 29'($random(seed));
        for (int k = 0; k < 2; k++)
        begin
            @(negedge ref_clk_i);
            mem_err_addr_i = k ? ~m1 : m1;
            mem_err_i = 1'b1;
            @(negedge ref_clk_i);
            mem_err_i = 1'b0;
        end
        rd(ADDR_DMA_SYS_ERR, 33'h18);
        rd(ADDR_LM_ERR_PAGE, {13'h0, m1[28:9]});
        dcok_i = 1'b0;
        repeat (6) @(negedge ref_clk_i);
        dcok_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        rd(ADDR_DMA_SYS_ERR, 33'h0);
        bpok_i = 1'b0;
        wt(1, 1'b1, 20);
        check("trap", {32'h0, power_fail_trap_o}, 33'h1);
        rd(ADDR_SYS_CONFIG, 33'h0);
        dma_req_i = 1'b1;
        wt(2, 1'b1, 20);
        wt(2, 1'b0, 1400);
        check("no_ack_wait", 33'(n >= NO_ACK_CYC), 33'h1);
        wt(2, 1'b1, 200);
        check("chain_clear", 33'(n >= CHAIN_CLEAR_CYC), 33'h1);
        dma_ack_i = 1'b1;
        wt(2, 1'b0, 20);
        check("ack_drop", 33'(n <= 4), 33'h1);
        dma_req_i = 1'b0;
        dma_ack_i = 1'b0;
        repeat (5) @(negedge ref_clk_i);
        report_and_stop();
    end
endmodule
